//--- bench/flash_unlock_asserts.sv
`timescale 1ns/1ps
`include "flash_unlock_regs.vh"
module flash_unlock_asserts #(parameter PAGE_SHIFT = 5) (
    // Bus side
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    // Flash side
    input wire flash_write_done,
    input wire flash_read_done,
    input wire flash_write_allowed,
    input wire cpu_halt,
    input wire [2:0] flash_mode,
    input wire [15:0] write_buffer,
    input wire [15:0] flash_address,
    input wire [15:0] erase_page
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire wr = hsel && hready && htrans[1] && hwrite;
    reg ctrl_dp;
    reg [3:0] since_key;
    // Saturates, so a flag rise long after the last key byte is caught
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_dp <= 1'b0;
            since_key <= 4'hf;
        end else begin
            ctrl_dp <= wr && haddr[7:0] == `OFS_CONTROL;
            if (wr && haddr[7:0] == `OFS_D3H) since_key <= 4'h0;
            else if (since_key != 4'hf) since_key <= since_key + 4'h1;
        end
    end
    sequence ctrl_wr; wr && haddr[7:0] == `OFS_CONTROL; endsequence
    sequence d0h_wr; wr && haddr[7:0] == `OFS_D0H; endsequence
    mode_follow_a: assert property (ctrl_wr |=> ##1 flash_mode == $past(hwdata[6:4]))
        else $error("mode not applied");
    flag_clear_a: assert property (ctrl_wr ##1 !hwdata[7] |=> !flash_write_allowed)
        else $error("flag not cleared");
    key_rise_a: assert property ($rose(flash_write_allowed) |-> since_key <= 4'h6)
        else $error("flag set without key");
    erase_map_a:
        assert property (erase_page == {{PAGE_SHIFT{1'b0}}, flash_address[15:PAGE_SHIFT]})
        else $error("erase page wrong");
    buffer_load_a: assert property (d0h_wr |=> ##1 write_buffer[15:8] == $past(hwdata[7:0]))
        else $error("buffer not loaded");
    addr_step_a:
        assert property (d0h_wr |=> ##1 flash_address == $past(flash_address) + 16'h1
            || flash_address == 16'h0) else $error("address not stepped");
    halt_cause_a: assert property ($rose(cpu_halt) |-> $past(ctrl_dp))
        else $error("halt without request");
    halt_end_a:
        assert property ($fell(cpu_halt) |-> $past(flash_write_done) || $past(flash_read_done)
            || $past(ctrl_dp)) else $error("halt ended without completion");
endmodule
bind flash_unlock flash_unlock_asserts #(.PAGE_SHIFT(PAGE_SHIFT)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .flash_write_done(flash_write_done),
    .flash_read_done(flash_read_done), .flash_write_allowed(flash_write_allowed),
    .cpu_halt(cpu_halt), .flash_mode(flash_mode), .write_buffer(write_buffer),
    .flash_address(flash_address), .erase_page(erase_page));

//--- bench/tb_flash_unlock.sv
`timescale 1ns/1ps
`include "flash_unlock_regs.vh"
module tb_flash_unlock;
    localparam PS = 6;
    reg hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, tick = 1'b0, wdone = 1'b0, rd_dp = 1'b0;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0, rnd;
    reg [1:0] htrans = 2'h0;
    reg rdone = 1'b0;
    reg [8:0] tcnt = 9'h0;
    reg [15:0] fa;
    reg [31:0] expq[$];
    reg [7:0] kb[0:5] = '{`KEY0, `KEY1, `KEY2, `KEY3, `KEY4, `KEY5};
    reg [2:0] md[0:2] = '{`MODE_WRITE, `MODE_ERASE, `MODE_READ};
    integer n_errors = 0, checked = 0, seed = 32'h69db1ae7, i;
    wire hready, hresp, allowed, halt;
    wire [31:0] hrdata;
    wire [2:0] mode;
    wire [15:0] wbuf, faddr, epage;
    always #50 hclk = ~hclk;
    flash_unlock #(.PAGE_SHIFT(PS), .ADDR_HIGH_BITS(6)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .slow_osc_tick(tick), .flash_write_done(wdone), .flash_read_done(rdone),
        .flash_write_allowed(allowed), .cpu_halt(halt), .flash_mode(mode),
        .write_buffer(wbuf), .flash_address(faddr), .erase_page(epage));
    task check(input [31:0] seen, input [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Slow oscillator tick every 313 cycles; read results checked in order
    always @(posedge hclk) begin
        tcnt <= (tcnt == 9'h138) ? 9'h0 : tcnt + 9'h1;
        tick <= (tcnt == 9'h138);
        if (rd_dp) begin
            check(hrdata, expq.pop_front());
            check({30'h0, hresp, hready}, 32'h1);
        end
        rd_dp <= hready && htrans[1] && !hwrite;
    end
    task bus(input [7:0] a, input w, input [7:0] d);
        rnd = $random(seed);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {rnd[31:8], d};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask
    task rd(input [7:0] a, input [31:0] e);
        expq.push_back(e);
        bus(a, 1'b0, 8'h0);
    endtask
    // Values launched at the previous edge are read before this edge updates them
    task settle;
        @(posedge hclk);
    endtask
    task flash_op(input [7:0] ctl, input rdop);
        bus(`OFS_CONTROL, 1'b1, ctl);
        settle;
        check({31'h0, halt}, 32'h1);
        if (rdop) rdone <= 1'b1;
        else wdone <= 1'b1;
        @(posedge hclk);
        rdone <= 1'b0;
        wdone <= 1'b0;
        settle;
        check({31'h0, halt}, 32'h0);
    endtask
    task unlock(input [7:0] bad);
        bus(`OFS_CONTROL, 1'b1, 8'h68);
        for (i = 0; i < 6; i = i + 1)
            bus(`OFS_D1L + {i[5:0], 2'h0}, 1'b1, kb[i] ^ (i == 5 ? bad : 8'h0));
        repeat (4) @(posedge hclk);
    endtask
    task complete_run;
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (i = 0; i < 13; i = i + 1) rd({i[5:0], 2'h0}, 32'h0);
        rd(8'h3c, 32'h0);
        rd(`OFS_STATUS, 32'h1);
        for (i = 5; i < 11; i = i + 1) begin
            fa = 16'($random(seed));
            bus({i[5:0], 2'h0}, 1'b1, fa[7:0]);
            rd({i[5:0], 2'h0}, {24'h0, fa[7:0]});
        end
        bus(`OFS_CONTROL, 1'b1, 8'h80);
        rd(`OFS_CONTROL, 32'h0);
        for (i = 0; i < 3; i = i + 1) begin
            bus(`OFS_CONTROL, 1'b1, {1'b0, md[i], 4'h0});
            settle;
            check({29'h0, mode}, {29'h0, md[i]});
        end
        fa = 16'($random(seed));
        bus(`OFS_ADDR_LOW, 1'b1, fa[7:0]);
        bus(`OFS_ADDR_HIGH, 1'b1, fa[15:8]);
        fa = fa & 16'h3fff;
        settle;
        check({16'h0, epage}, {22'h0, fa[15:PS]});
        bus(`OFS_D0L, 1'b1, 8'haa);
        bus(`OFS_D0H, 1'b1, 8'h55);
        settle;
        check({16'h0, wbuf}, 32'h55aa);
        check({16'h0, faddr}, {16'h0, (fa + 16'h1) & 16'h3fff});
        unlock(8'h01);
        rd(`OFS_CONTROL, 32'h60);
        bus(`OFS_CONTROL, 1'b1, 8'h68);
        repeat (2500) @(posedge hclk);
        rd(`OFS_STATUS, 32'h2);
        repeat (1100) @(posedge hclk);
        rd(`OFS_CONTROL, 32'h60);
        unlock(8'h00);
        rd(`OFS_CONTROL, 32'he0);
        check({31'h0, allowed}, 32'h1);
        flash_op(8'h94, 1'b0);
        flash_op(8'h84, 1'b0);
        bus(`OFS_CONTROL, 1'b1, 8'h60);
        rd(`OFS_CONTROL, 32'h60);
        check({31'h0, allowed}, 32'h0);
        flash_op(8'h07, 1'b1);
        rd(`OFS_CONTROL, 32'h2);
        repeat (3) @(posedge hclk);
        complete_run;
    end
    // Whole run is about 4000 cycles; this cuts a hang well beyond that
    initial begin
        #1000000;
        n_errors = n_errors + 1;
        complete_run;
    end
endmodule

//--- hw/flash_unlock.v
`timescale 1ns/1ps
`include "flash_unlock_regs.vh"

// Operation
// - Procedure enable bit accepted in same write as mode, or later.
// - Starting the procedure starts a 300 us time-out for the key.
// - Time-out counter ticks on the slow internal oscillator.
// - Time-out or wrong key leaves writing off and clears procedure enable.
// - Correct key in time sets write-enabled flag, clears procedure enable.
// - Write-enabled flag permits flash modification through control registers.
// - Software clearing write-enabled flag disables flash writing.
// - Erase page is 32, 64 or 128 words, fixed per variant.
// - Erase page from high address plus low bits 7:5, 7:6 or 7.
// - Three extra 16-bit data words as low/high byte register pairs.
// - Processor halts while write-initiate or read-initiate is set.
// - Mode decode: 000 write, 001 erase, 011 read, 110 unlock.
// - Software writing 1 to write-enabled flag has no effect.
// - Write-initiate clears by hardware when flash write completes.
// - First data high byte write loads buffer, increments address.
module flash_unlock #(
    parameter PAGE_SHIFT = 5,
    parameter ADDR_HIGH_BITS = 5
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Slow internal oscillator tick, one hclk cycle per oscillator edge
    input wire slow_osc_tick,
    // Flash macro
    input wire flash_write_done,
    input wire flash_read_done,
    output wire flash_write_allowed,
    output wire cpu_halt,
    output wire [2:0] flash_mode,
    output reg [15:0] write_buffer,
    output wire [15:0] flash_address,
    output wire [15:0] erase_page
);
    localparam TIMEOUT_TICKS = (`UNLOCK_TIMEOUT_NS + `SLOW_OSC_PERIOD_NS - 1) /
        `SLOW_OSC_PERIOD_NS;
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_WAIT = 2'b10;

    reg [7:0] control;
    reg [7:0] address_low_register;
    reg [7:0] address_high_register;
    reg [7:0] first_data_word_low;
    reg [7:0] first_data_word_high;
    reg [7:0] second_data_word_low;
    reg [7:0] second_data_word_high;
    reg [7:0] third_data_word_low;
    reg [7:0] third_data_word_high;
    reg [7:0] fourth_data_word_low;
    reg [7:0] fourth_data_word_high;
    reg [1:0] state;
    reg [7:0] timeout_count;
    reg key_last_written;
    reg wr_pend;
    reg [7:0] wr_addr;

    wire [7:0] wd = hwdata[7:0];
    wire take = hsel & hready & htrans[1];
    wire do_write = wr_pend;
    wire [2:0] operation_mode_field = control[`MODE_HI:`MODE_LO];
    wire write_enabled_flag = control[`BIT_WEN];
    wire unlock_procedure_enable = control[`BIT_PEN];
    wire write_unlock_mode = (operation_mode_field == `MODE_UNLOCK);
    wire [7:0] high_mask = 8'hff >> (8 - ADDR_HIGH_BITS);
    wire [5:0] key_hit;
    wire key_ok = &key_hit;
    wire timed_out = (state == ST_WAIT) && slow_osc_tick &&
        (timeout_count == TIMEOUT_TICKS[7:0] - 8'h01);
    wire ctl_wr = do_write && (wr_addr == `OFS_CONTROL);
    wire d0h_wr = do_write && (wr_addr == `OFS_D0H);
    wire [15:0] next_addr = {address_high_register, address_low_register} + 16'h0001;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign flash_write_allowed = write_enabled_flag;
    assign cpu_halt = control[`BIT_WINIT] | control[`BIT_RINIT];
    assign flash_mode = operation_mode_field;
    assign flash_address = {address_high_register, address_low_register};
    // Words inside the page are don't-care; shift them out
    assign erase_page = flash_address >> PAGE_SHIFT;

    // One comparator per key byte; a single wrong byte fails the whole key
    key_byte_match #(
        .EXPECTED(`KEY0)
    ) u_key0 (
        .value(second_data_word_low),
        .hit(key_hit[0])
    );

    key_byte_match #(
        .EXPECTED(`KEY1)
    ) u_key1 (
        .value(second_data_word_high),
        .hit(key_hit[1])
    );

    key_byte_match #(
        .EXPECTED(`KEY2)
    ) u_key2 (
        .value(third_data_word_low),
        .hit(key_hit[2])
    );

    key_byte_match #(
        .EXPECTED(`KEY3)
    ) u_key3 (
        .value(third_data_word_high),
        .hit(key_hit[3])
    );

    key_byte_match #(
        .EXPECTED(`KEY4)
    ) u_key4 (
        .value(fourth_data_word_low),
        .hit(key_hit[4])
    );

    key_byte_match #(
        .EXPECTED(`KEY5)
    ) u_key5 (
        .value(fourth_data_word_high),
        .hit(key_hit[5])
    );

    // Address phase capture; slave is zero-wait so writes land one cycle later
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= take & hwrite;
            wr_addr <= {haddr[7:2], 2'b00};
        end
    end

    // Read data, registered in the address phase, driven in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (take & ~hwrite) begin
            case ({haddr[7:2], 2'b00})
                `OFS_CONTROL: hrdata <= {24'h000000, control};
                `OFS_ADDR_LOW: hrdata <= {24'h000000, address_low_register};
                `OFS_ADDR_HIGH: hrdata <= {24'h000000, address_high_register};
                `OFS_D0L: hrdata <= {24'h000000, first_data_word_low};
                `OFS_D0H: hrdata <= {24'h000000, first_data_word_high};
                `OFS_D1L: hrdata <= {24'h000000, second_data_word_low};
                `OFS_D1H: hrdata <= {24'h000000, second_data_word_high};
                `OFS_D2L: hrdata <= {24'h000000, third_data_word_low};
                `OFS_D2H: hrdata <= {24'h000000, third_data_word_high};
                `OFS_D3L: hrdata <= {24'h000000, fourth_data_word_low};
                `OFS_D3H: hrdata <= {24'h000000, fourth_data_word_high};
                `OFS_WBUF: hrdata <= {16'h0000, write_buffer};
                `OFS_PAGE: hrdata <= {16'h0000, erase_page};
                `OFS_STATUS: hrdata <= {30'h00000000, state};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // Data registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_data_word_low <= 8'h00;
            first_data_word_high <= 8'h00;
            second_data_word_low <= 8'h00;
            second_data_word_high <= 8'h00;
            third_data_word_low <= 8'h00;
            third_data_word_high <= 8'h00;
            fourth_data_word_low <= 8'h00;
            fourth_data_word_high <= 8'h00;
            write_buffer <= 16'h0000;
        end else if (do_write) begin
            case (wr_addr)
                `OFS_D0L: first_data_word_low <= wd;
                `OFS_D0H: begin
                    first_data_word_high <= wd;
                    write_buffer <= {wd, first_data_word_low};
                end
                `OFS_D1L: second_data_word_low <= wd;
                `OFS_D1H: second_data_word_high <= wd;
                `OFS_D2L: third_data_word_low <= wd;
                `OFS_D2H: third_data_word_high <= wd;
                `OFS_D3L: fourth_data_word_low <= wd;
                `OFS_D3H: fourth_data_word_high <= wd;
                default: ;
            endcase
        end
    end

    // Address pair; the first data word high-byte write auto-increments it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            address_low_register <= 8'h00;
            address_high_register <= 8'h00;
        end else if (d0h_wr) begin
            address_low_register <= next_addr[7:0];
            address_high_register <= next_addr[15:8] & high_mask;
        end else if (do_write && wr_addr == `OFS_ADDR_LOW) begin
            address_low_register <= wd;
        end else if (do_write && wr_addr == `OFS_ADDR_HIGH) begin
            address_high_register <= wd & high_mask;
        end
    end

    // Key check is armed by the last key byte so the compare sees a full key
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_last_written <= 1'b0;
        end else begin
            key_last_written <= do_write && (wr_addr == `OFS_D3H);
        end
    end

    // Unlock sequencer; the time-out runs only on slow oscillator ticks
    // The first tick lands anywhere in its period, so the window is nine to ten periods
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            timeout_count <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    timeout_count <= 8'h00;
                    if (unlock_procedure_enable && write_unlock_mode) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (slow_osc_tick) begin
                        timeout_count <= timeout_count + 8'h01;
                    end
                    if (key_last_written || timed_out || !unlock_procedure_enable) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    wire unlock_end = (state == ST_WAIT) && (key_last_written || timed_out);
    wire unlock_pass = (state == ST_WAIT) && key_last_written && key_ok && !timed_out;

    // Control register; hardware set beats software clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control <= `CONTROL_RESET;
        end else begin
            if (ctl_wr) begin
                control[`MODE_HI:`MODE_LO] <= wd[`MODE_HI:`MODE_LO];
                control[`BIT_PEN] <= wd[`BIT_PEN];
                control[`BIT_RDEN] <= wd[`BIT_RDEN];
                control[`BIT_WINIT] <= wd[`BIT_WINIT] & write_enabled_flag;
                control[`BIT_RINIT] <= wd[`BIT_RINIT] & wd[`BIT_RDEN];
                if (!wd[`BIT_WEN]) begin
                    control[`BIT_WEN] <= 1'b0;
                end
            end
            if (flash_write_done) begin
                control[`BIT_WINIT] <= 1'b0;
            end
            if (flash_read_done) begin
                control[`BIT_RINIT] <= 1'b0;
            end
            if (unlock_end) begin
                control[`BIT_PEN] <= 1'b0;
            end
            if (unlock_pass) begin
                control[`BIT_WEN] <= 1'b1;
            end
        end
    end
endmodule

// Compares one stored byte against a fixed key value
module key_byte_match #(
    parameter [7:0] EXPECTED = 8'h00
) (
    // Stored byte
    input wire [7:0] value,
    // Match result
    output wire hit
);
    assign hit = (value == EXPECTED);
endmodule

//--- hw/flash_unlock_regs.vh
`ifndef FLASH_UNLOCK_REGS_VH
`define FLASH_UNLOCK_REGS_VH
// Register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_ADDR_LOW 8'h04
`define OFS_ADDR_HIGH 8'h08
`define OFS_D0L 8'h0c
`define OFS_D0H 8'h10
`define OFS_D1L 8'h14
`define OFS_D1H 8'h18
`define OFS_D2L 8'h1c
`define OFS_D2H 8'h20
`define OFS_D3L 8'h24
`define OFS_D3H 8'h28
`define OFS_WBUF 8'h2c
`define OFS_PAGE 8'h30
`define OFS_STATUS 8'h34
// Control fields
`define BIT_WEN 7
`define MODE_HI 6
`define MODE_LO 4
`define BIT_PEN 3
`define BIT_WINIT 2
`define BIT_RDEN 1
`define BIT_RINIT 0
`define CONTROL_RESET 8'h00
// Mode encodings
`define MODE_WRITE 3'h0
`define MODE_ERASE 3'h1
`define MODE_READ 3'h3
`define MODE_UNLOCK 3'h6
// Key bytes
`define KEY0 8'h00
`define KEY1 8'h04
`define KEY2 8'h0d
`define KEY3 8'h09
`define KEY4 8'hc3
`define KEY5 8'h40
// Time-out in ns and oscillator period in ns
`define UNLOCK_TIMEOUT_NS 300000
`define SLOW_OSC_PERIOD_NS 31250
`endif
